// file: ssf_defines.svh
// Register map, field positions and reset values of the system special-function bank
// Notes on behaviour
// RQ1: Enables for NMI, vacant, osc, watchdog; reset 0
// RQ2: Reserved bits ignore writes, read zero
// RQ3: Watchdog enable gates interval flag only
// RQ4: Out-ready flag clears when CPU fills words
// RQ5: Out-ready flag sets when debug collected words
// RQ6: Vector read clears returned mailbox flag
// RQ7: In-pending flag clears when CPU reads words
// RQ8: In-pending flag sets when debug wrote words
// RQ9: Pending flags NMI, vacant, osc; osc resets 1
// RQ10: Watchdog mode timeout clears flag, records cause
// RQ11: Interval flag clears on service or write
// RQ12: Pin control bit 3 enables pull resistor
// RQ13: Pin control bit 2 selects pull direction
// RQ14: Pin control bit 0 selects reset/NMI function
// RQ15: Pin control bit 1 selects NMI edge
// RQ16: Software changes edge only in reset function; code accepts edge writes in NMI function too
// RQ17: Word aligned registers, byte lane writes
// RQ18: Dedicated debug pins bit sets once, sticky
// RQ19: Boot entry bit shows detected entry sequence
// RQ20: Power regs protect sticky until brownout reset
// RQ21: Bit 0 selects flash or RAM vectors
// RQ22: Mailbox mode selects one or two words
// RQ23: Interrupt request when flag and enable set
`ifndef SSF_DEFINES_SVH
`define SSF_DEFINES_SVH
// ==========================================================
// Register indices, byte address is four times the index
`define SSF_IDX_SYS_CTL    6'h00
`define SSF_IDX_BOOT_CFG   6'h02
`define SSF_IDX_MB_CTL     6'h06
`define SSF_IDX_MB_IN0     6'h08
`define SSF_IDX_MB_IN1     6'h0A
`define SSF_IDX_MB_OUT0    6'h0C
`define SSF_IDX_MB_OUT1    6'h0E
`define SSF_IDX_BUS_ERR_IV 6'h18
`define SSF_IDX_USER_NMI_IV 6'h1A
`define SSF_IDX_SYS_NMI_IV 6'h1C
`define SSF_IDX_RST_IV     6'h1E
`define SSF_IDX_IRQ_EN     6'h20
`define SSF_IDX_IRQ_FLAGS  6'h22
`define SSF_IDX_PIN_CTL    6'h24
// ==========================================================
// Field positions
`define SSF_B_MB_OUT   7
`define SSF_B_MB_IN    6
`define SSF_B_NMI      4
`define SSF_B_VACANT   3
`define SSF_B_OSC      1
`define SSF_B_WDT      0
`define SSF_B_PULL_EN  3
`define SSF_B_PULL_UP  2
`define SSF_B_EDGE     1
`define SSF_B_FUNC     0
`define SSF_B_DBG_PINS 5
`define SSF_B_BOOT_IND 4
`define SSF_B_PWR_PROT 2
`define SSF_B_RAM_VEC  0
`define SSF_B_MB_MODE  4
// ==========================================================
// Writable masks and reset values
`define SSF_MASK_IRQ   16'h00DB
`define SSF_MASK_PIN   16'h000F
`define SSF_MASK_SYS   16'h0035
`define SSF_MASK_BOOT  16'hC007
`define SSF_MASK_MBC   16'h0010
`define SSF_RST_FLAGS  16'h0082
`define SSF_RST_PIN    16'h000C
`define SSF_RST_BOOT   16'h0003
`define SSF_RST_CAUSE  16'h0002
`define SSF_CAUSE_WDT  16'h0016
// ==========================================================
// Vector codes
`define SSF_IV_NMI     16'h0002
`define SSF_IV_OSC     16'h0004
`define SSF_IV_VACANT  16'h000A
`define SSF_IV_MB_IN   16'h000C
`define SSF_IV_MB_OUT  16'h000E
`endif

// file: ssf_pkg.sv
// Types shared by the system special-function bank
package ssf_pkg;
  // Bus answer state, Gray along the path
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_ANSWER = 2'b01
  } ssf_bus_e;
  typedef logic [15:0] ssf_word_t;
endpackage

// file: ssf_pin_edge.sv
// Synchroniser and edge detector for the reset/NMI pin
`timescale 1ns/1ps
`default_nettype none
module ssf_pin_edge (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pin,
  output logic      rise,
  output logic      fall
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  // Two stages before anyone looks; pin idles high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      prev_q <= 1'b1;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign rise = sync_q & ~prev_q;
  assign fall = ~sync_q & prev_q;
endmodule // ssf_pin_edge
`default_nettype wire

// file: ssf_regs.sv
// System special-function register bank with APB slave
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ssf_defines.svh"
module ssf_regs (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        nmi_pin,
  input  wire logic        vacant_access_evt,
  input  wire logic        osc_fault_evt,
  input  wire logic        wdt_interval_evt,
  input  wire logic        wdt_timeout_evt,
  input  wire logic        wdt_watchdog_mode,
  input  wire logic        wdt_irq_ack,
  input  wire logic        boot_entry_detect,
  input  wire logic [1:0]  dbg_in_wr,
  input  wire logic [15:0] dbg_in_data,
  input  wire logic [1:0]  dbg_out_rd,
  output logic      [15:0] mailbox_output_word0,
  output logic      [15:0] mailbox_output_word1,
  output logic             nmi_pin_irq,
  output logic             vacant_access_irq,
  output logic             osc_fault_irq,
  output logic             watchdog_interval_irq,
  output logic             mailbox_in_irq,
  output logic             mailbox_out_irq,
  output logic             watchdog_reset_req,
  output logic             reset_pin_pull_enable,
  output logic             reset_pin_pull_direction,
  output logic             reset_pin_function_select,
  output logic             nmi_edge_select,
  output logic             dedicated_debug_pins,
  output logic             power_regs_protect,
  output logic             ram_vector_select
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ==========================================================
  // Helpers
  // Byte lane merge; reserved bits forced to zero
  function automatic ssf_pkg::ssf_word_t merge(input ssf_pkg::ssf_word_t old,
                                               input logic [31:0] wd,
                                               input logic [3:0] st,
                                               input ssf_pkg::ssf_word_t msk);
    ssf_pkg::ssf_word_t nv;
    nv = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
    return nv & msk; // RQ2 RQ17
  endfunction

  // Completion of a one- or two-word transfer
  function automatic logic both_done(input logic mode, input logic [1:0] seen,
                                     input logic [1:0] now);
    logic [1:0] all;
    all = seen | now;
    return mode ? (all == 2'b11) : all[0]; // RQ22
  endfunction

  // ==========================================================
  // State
  ssf_pkg::ssf_bus_e  st_q;
  ssf_pkg::ssf_word_t ie_q, flags_q, flags_d, pin_q, sys_q, boot_q, cause_q;
  ssf_pkg::ssf_word_t mbc_q, rd_val, univ;
  ssf_pkg::ssf_word_t in_word_q [2];
  ssf_pkg::ssf_word_t out_word_q [2];
  logic [31:0] prdata_q;
  logic        pready_q, pslverr_q, mapped;
  logic [1:0]  dbg_got_q, cpu_rd_q, cpu_wr_q, dbg_rd_q;
  logic        irq_nmi_q, irq_vac_q, irq_osc_q, irq_wdt_q, irq_in_q, irq_out_q;
  logic        wdt_rst_q;
  logic [5:0]  aidx;
  logic        done, wr_any, rd_any, mode;
  logic [1:0]  in_rd_now, out_wr_now;
  logic        in_set, in_clr, out_set, out_clr, univ_rd, univ_wr;
  logic        nmi_rise, nmi_fall, nmi_evt;

  assign aidx   = paddr[7:2];
  assign done   = (st_q == ssf_pkg::ST_ANSWER) && psel && penable;
  assign wr_any = done && pwrite && mapped;
  assign rd_any = done && !pwrite && mapped;
  assign mode   = mbc_q[`SSF_B_MB_MODE];

  // ==========================================================
  // Address decode and read mux
  always_comb begin
    rd_val = '0;
    mapped = 1'b1;
    if (aidx == `SSF_IDX_SYS_CTL)          rd_val = sys_q;
    else if (aidx == `SSF_IDX_BOOT_CFG)    rd_val = boot_q;
    else if (aidx == `SSF_IDX_MB_CTL)      rd_val = mbc_q;
    else if (aidx == `SSF_IDX_MB_IN0)      rd_val = in_word_q[0];
    else if (aidx == `SSF_IDX_MB_IN1)      rd_val = in_word_q[1];
    else if (aidx == `SSF_IDX_MB_OUT0)     rd_val = out_word_q[0];
    else if (aidx == `SSF_IDX_MB_OUT1)     rd_val = out_word_q[1];
    else if (aidx == `SSF_IDX_BUS_ERR_IV)  rd_val = '0;
    else if (aidx == `SSF_IDX_USER_NMI_IV) rd_val = univ;
    else if (aidx == `SSF_IDX_SYS_NMI_IV)
      rd_val = flags_q[`SSF_B_VACANT] ? `SSF_IV_VACANT : 16'h0000;
    else if (aidx == `SSF_IDX_RST_IV)      rd_val = cause_q;
    else if (aidx == `SSF_IDX_IRQ_EN)      rd_val = ie_q;
    else if (aidx == `SSF_IDX_IRQ_FLAGS)   rd_val = flags_q;
    else if (aidx == `SSF_IDX_PIN_CTL)     rd_val = pin_q;
    else                                   mapped = 1'b0;
  end

  // User NMI vector, highest priority first
  always_comb begin
    univ = '0;
    if (flags_q[`SSF_B_NMI])         univ = `SSF_IV_NMI;
    else if (flags_q[`SSF_B_OSC])    univ = `SSF_IV_OSC;
    else if (flags_q[`SSF_B_MB_IN])  univ = `SSF_IV_MB_IN;
    else if (flags_q[`SSF_B_MB_OUT]) univ = `SSF_IV_MB_OUT;
  end

  // ==========================================================
  // APB answer: data is latched in setup so prdata is a flop; one wait-free access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q      <= ssf_pkg::ST_IDLE;
      prdata_q  <= '0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      case (st_q)
        ssf_pkg::ST_IDLE: begin
          if (psel && !penable) begin
            st_q      <= ssf_pkg::ST_ANSWER;
            prdata_q  <= {16'h0000, rd_val}; // RQ2
            pready_q  <= 1'b1;
            pslverr_q <= !mapped;
          end
        end
        default: begin
          if (done) begin
            st_q      <= ssf_pkg::ST_IDLE;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Mailbox events from both sides
  assign in_rd_now[0]  = rd_any && aidx == `SSF_IDX_MB_IN0;
  assign in_rd_now[1]  = rd_any && aidx == `SSF_IDX_MB_IN1;
  assign out_wr_now[0] = wr_any && aidx == `SSF_IDX_MB_OUT0;
  assign out_wr_now[1] = wr_any && aidx == `SSF_IDX_MB_OUT1;
  assign in_set  = both_done(mode, dbg_got_q, dbg_in_wr);  // RQ8
  assign in_clr  = both_done(mode, cpu_rd_q, in_rd_now);   // RQ7
  assign out_set = both_done(mode, dbg_rd_q, dbg_out_rd);  // RQ5
  assign out_clr = both_done(mode, cpu_wr_q, out_wr_now);  // RQ4
  assign univ_rd = rd_any && aidx == `SSF_IDX_USER_NMI_IV;
  assign univ_wr = wr_any && aidx == `SSF_IDX_USER_NMI_IV;

  // Partial-transfer trackers restart once a transfer completes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dbg_got_q <= '0;
      cpu_rd_q  <= '0;
      cpu_wr_q  <= '0;
      dbg_rd_q  <= '0;
    end else begin
      dbg_got_q <= in_set  ? 2'b00 : dbg_got_q | dbg_in_wr;
      cpu_rd_q  <= in_clr  ? 2'b00 : cpu_rd_q | in_rd_now;
      cpu_wr_q  <= out_clr ? 2'b00 : cpu_wr_q | out_wr_now;
      dbg_rd_q  <= out_set ? 2'b00 : dbg_rd_q | dbg_out_rd;
    end
  end

  // Mailbox words; input words are read-only to the CPU
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_word_q[0]  <= '0;
      in_word_q[1]  <= '0;
      out_word_q[0] <= '0;
      out_word_q[1] <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (dbg_in_wr[i])
          in_word_q[i] <= dbg_in_data;
        if (out_wr_now[i])
          out_word_q[i] <= merge(out_word_q[i], pwdata, pstrb, 16'hFFFF); // RQ17
      end
    end
  end

  // ==========================================================
  // NMI pin: synchronised, edge chosen by pin control
  ssf_pin_edge u_pin_edge (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (nmi_pin),
    .rise    (nmi_rise),
    .fall    (nmi_fall)
  );
  assign nmi_evt = pin_q[`SSF_B_FUNC] && (pin_q[`SSF_B_EDGE] ? nmi_fall : nmi_rise); // RQ14 RQ15

  // ==========================================================
  // Pending flags: clears first, hardware sets last so a set wins
  always_comb begin
    flags_d = flags_q;
    if (wr_any && aidx == `SSF_IDX_IRQ_FLAGS)
      flags_d = merge(flags_q, pwdata, pstrb, `SSF_MASK_IRQ); // RQ9 RQ11
    if (univ_wr) begin
      flags_d[`SSF_B_NMI] = 1'b0;
      flags_d[`SSF_B_OSC] = 1'b0;
    end
    if (in_clr || (univ_rd && univ == `SSF_IV_MB_IN))
      flags_d[`SSF_B_MB_IN] = 1'b0; // RQ6 RQ7
    if (out_clr || (univ_rd && univ == `SSF_IV_MB_OUT))
      flags_d[`SSF_B_MB_OUT] = 1'b0; // RQ4 RQ6
    if (wdt_watchdog_mode ? wdt_timeout_evt : wdt_irq_ack)
      flags_d[`SSF_B_WDT] = 1'b0; // RQ10 RQ11
    if (in_set)
      flags_d[`SSF_B_MB_IN] = 1'b1; // RQ8
    if (out_set)
      flags_d[`SSF_B_MB_OUT] = 1'b1; // RQ5
    if (nmi_evt)
      flags_d[`SSF_B_NMI] = 1'b1;
    if (vacant_access_evt)
      flags_d[`SSF_B_VACANT] = 1'b1;
    if (osc_fault_evt)
      flags_d[`SSF_B_OSC] = 1'b1;
    if (wdt_interval_evt && !wdt_watchdog_mode)
      flags_d[`SSF_B_WDT] = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      flags_q <= `SSF_RST_FLAGS; // RQ9
    else
      flags_q <= flags_d;
  end

  // ==========================================================
  // Software control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ie_q   <= '0; // RQ1
      pin_q  <= `SSF_RST_PIN; // RQ12 RQ13
      boot_q <= `SSF_RST_BOOT;
      mbc_q  <= '0;
    end else if (wr_any) begin
      if (aidx == `SSF_IDX_IRQ_EN)
        ie_q <= merge(ie_q, pwdata, pstrb, `SSF_MASK_IRQ); // RQ1 RQ2
      else if (aidx == `SSF_IDX_PIN_CTL)
        pin_q <= merge(pin_q, pwdata, pstrb, `SSF_MASK_PIN); // RQ12 RQ13 RQ14 RQ15
      else if (aidx == `SSF_IDX_BOOT_CFG)
        boot_q <= merge(boot_q, pwdata, pstrb, `SSF_MASK_BOOT);
      else if (aidx == `SSF_IDX_MB_CTL)
        mbc_q <= merge(mbc_q, pwdata, pstrb, `SSF_MASK_MBC); // RQ22
    end
  end

  // System control: sticky bits only ever set; presetn is the brownout reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      sys_q <= '0;
    else begin
      if (wr_any && aidx == `SSF_IDX_SYS_CTL) begin
        sys_q <= merge(sys_q, pwdata, pstrb, `SSF_MASK_SYS); // RQ21
        sys_q[`SSF_B_DBG_PINS] <= sys_q[`SSF_B_DBG_PINS] |
                                  (pstrb[0] & pwdata[`SSF_B_DBG_PINS]); // RQ18
        sys_q[`SSF_B_PWR_PROT] <= sys_q[`SSF_B_PWR_PROT] |
                                  (pstrb[0] & pwdata[`SSF_B_PWR_PROT]); // RQ20
      end
      if (boot_entry_detect)
        sys_q[`SSF_B_BOOT_IND] <= 1'b1; // RQ19
    end
  end

  // Reset cause survives until the next power-up reset of this bank
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      cause_q <= `SSF_RST_CAUSE;
    else if (wdt_timeout_evt && wdt_watchdog_mode)
      cause_q <= `SSF_CAUSE_WDT; // RQ10
  end

  // ==========================================================
  // Interrupt requests and watchdog reset, registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_nmi_q <= 1'b0;
      irq_vac_q <= 1'b0;
      irq_osc_q <= 1'b0;
      irq_wdt_q <= 1'b0;
      irq_in_q  <= 1'b0;
      irq_out_q <= 1'b0;
      wdt_rst_q <= 1'b0;
    end else begin
      irq_nmi_q <= flags_q[`SSF_B_NMI] & ie_q[`SSF_B_NMI]; // RQ23
      irq_vac_q <= flags_q[`SSF_B_VACANT] & ie_q[`SSF_B_VACANT];
      irq_osc_q <= flags_q[`SSF_B_OSC] & ie_q[`SSF_B_OSC];
      irq_wdt_q <= flags_q[`SSF_B_WDT] & ie_q[`SSF_B_WDT] & !wdt_watchdog_mode; // RQ3
      irq_in_q  <= flags_q[`SSF_B_MB_IN] & ie_q[`SSF_B_MB_IN];
      irq_out_q <= flags_q[`SSF_B_MB_OUT] & ie_q[`SSF_B_MB_OUT];
      wdt_rst_q <= wdt_timeout_evt & wdt_watchdog_mode; // RQ3
    end
  end

  // ==========================================================
  // Output wiring, all from flops
  assign prdata                    = prdata_q;
  assign pready                    = pready_q;
  assign pslverr                   = pslverr_q;
  assign mailbox_output_word0      = out_word_q[0];
  assign mailbox_output_word1      = out_word_q[1];
  assign nmi_pin_irq               = irq_nmi_q;
  assign vacant_access_irq         = irq_vac_q;
  assign osc_fault_irq             = irq_osc_q;
  assign watchdog_interval_irq     = irq_wdt_q;
  assign mailbox_in_irq            = irq_in_q;
  assign mailbox_out_irq           = irq_out_q;
  assign watchdog_reset_req        = wdt_rst_q;
  assign reset_pin_pull_enable     = pin_q[`SSF_B_PULL_EN];
  assign reset_pin_pull_direction  = pin_q[`SSF_B_PULL_UP];
  assign reset_pin_function_select = pin_q[`SSF_B_FUNC];
  assign nmi_edge_select           = pin_q[`SSF_B_EDGE];
  assign dedicated_debug_pins      = sys_q[`SSF_B_DBG_PINS];
  assign power_regs_protect        = sys_q[`SSF_B_PWR_PROT];
  assign ram_vector_select         = sys_q[`SSF_B_RAM_VEC];

  // ==========================================================
  // Assertions
  a_flag_reserved: assert property (done && !pwrite && aidx == `SSF_IDX_IRQ_FLAGS |-> // RQ2
    prdata[15:8] == 8'h00 && !prdata[5] && !prdata[2]) else $error("reserved flag bits read nonzero");
  a_wdt_reset_req: assert property (wdt_timeout_evt && wdt_watchdog_mode |=> watchdog_reset_req) // RQ3
    else $error("watchdog timeout did not request reset");
  a_wdt_self_clear: assert property (wdt_timeout_evt && wdt_watchdog_mode |=> // RQ10
    !flags_q[`SSF_B_WDT] && cause_q == `SSF_CAUSE_WDT) else $error("watchdog timeout not handled");
  a_wdt_ack_clear: assert property (wdt_irq_ack && !wdt_watchdog_mode && !wdt_interval_evt |=> // RQ11
    !flags_q[`SSF_B_WDT]) else $error("serviced interval flag still set");
  a_mb_in_set: assert property (in_set |=> flags_q[`SSF_B_MB_IN]) // RQ8
    else $error("input flag not set");
  a_mb_in_clear: assert property (in_clr && !in_set |=> !flags_q[`SSF_B_MB_IN]) // RQ7
    else $error("input flag not cleared by reads");
  a_mb_out_clear: assert property (out_clr && !out_set |=> !flags_q[`SSF_B_MB_OUT]) // RQ4
    else $error("output flag not cleared by writes");
  a_mb_out_set: assert property (out_set |=> flags_q[`SSF_B_MB_OUT]) // RQ5
    else $error("output flag not set");
  a_vec_clear: assert property (univ_rd && univ == `SSF_IV_MB_IN && !in_set |=> // RQ6
    !flags_q[`SSF_B_MB_IN]) else $error("vector read left flag");
  a_debug_sticky: assert property (dedicated_debug_pins |=> dedicated_debug_pins) // RQ18
    else $error("debug pin bit cleared");
  a_prot_sticky: assert property (power_regs_protect |=> power_regs_protect) // RQ20
    else $error("protect bit cleared");
  a_irq_gate: assert property (##1 nmi_pin_irq == $past(flags_q[`SSF_B_NMI] & ie_q[`SSF_B_NMI])) // RQ23
    else $error("nmi request mismatch");
  a_bus_answer: assert property (psel && !penable && st_q == ssf_pkg::ST_IDLE |=> pready ##1 !pready)
    else $error("no one-cycle answer");
  c_two_word_in: cover property (mode && in_set);
  c_wdt_timeout: cover property (wdt_timeout_evt && wdt_watchdog_mode);
  c_vec_read_mb: cover property (univ_rd && univ == `SSF_IV_MB_OUT);
  c_nmi_event: cover property (nmi_evt);
endmodule // ssf_regs
`default_nettype wire

// file: ssf_dbg_port.sv
// Behavioural model of the debug port side of the mailbox
`timescale 1ns/1ps
`default_nettype none
module ssf_dbg_port (
  input  wire logic        pclk,
  output logic      [1:0]  dbg_in_wr,
  output logic      [15:0] dbg_in_data,
  output logic      [1:0]  dbg_out_rd
);
  // ==========================================================
  // Idle values; data shows no stale word between writes
  initial begin
    dbg_in_wr = 2'b00;
    dbg_in_data = 16'hFFFF;
    dbg_out_rd = 2'b00;
  end
  // Deliver one input word after gap idle cycles (slow or prompt)
  task automatic put(input int w, input int gap, input logic [15:0] d);
    repeat (gap) @(posedge pclk);
    dbg_in_wr[w] <= 1'b1;
    dbg_in_data <= d;
    @(posedge pclk);
    dbg_in_wr <= 2'b00;
    dbg_in_data <= ~d;
  endtask
  // Collect one output word after gap idle cycles
  task automatic take(input int w, input int gap);
    repeat (gap) @(posedge pclk);
    dbg_out_rd[w] <= 1'b1;
    @(posedge pclk);
    dbg_out_rd <= 2'b00;
  endtask
endmodule // ssf_dbg_port
`default_nettype wire

// file: system_special_function_regs_bench.sv
// Self-checking bench for the system special-function bank
`timescale 1ns/1ps
`default_nettype none
`include "ssf_defines.svh"
module system_special_function_regs_bench;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd_q;
  logic [3:0] pstrb = 4'h0;
  logic pready, pslverr, er_q, nmi_pin = 1'b1, wdt_watchdog_mode = 1'b0;
  logic [5:0] ev = 6'h00;
  wire logic vacant_access_evt = ev[0];
  wire logic osc_fault_evt = ev[1];
  wire logic wdt_interval_evt = ev[2];
  wire logic wdt_timeout_evt = ev[3];
  wire logic wdt_irq_ack = ev[4];
  wire logic boot_entry_detect = ev[5];
  logic [1:0] dbg_in_wr, dbg_out_rd;
  logic [15:0] dbg_in_data, mailbox_output_word0, mailbox_output_word1;
  logic nmi_pin_irq, vacant_access_irq, osc_fault_irq, watchdog_interval_irq, mailbox_in_irq;
  logic mailbox_out_irq, watchdog_reset_req, reset_pin_pull_enable, reset_pin_pull_direction;
  logic reset_pin_function_select, nmi_edge_select, dedicated_debug_pins, power_regs_protect;
  logic ram_vector_select;
  int fails = 0, total_checks = 0;
  ssf_regs uut (.*);
  ssf_dbg_port dbg (.pclk(pclk), .dbg_in_wr(dbg_in_wr), .dbg_in_data(dbg_in_data), .dbg_out_rd(dbg_out_rd));
  // ==========================================================
  // Clock
  always #5 pclk = ~pclk;
  // ==========================================================
  // Bus and check tasks
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Request held until pready is sampled high; no latency assumed
  task automatic xf(input logic w, input logic [5:0] i, input logic [15:0] d, input logic [3:0] s);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= {16'h0000, d};
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) fails++;
    rd_q = prdata;
    er_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge lets the write settle and keeps psel from being driven twice in one step
    @(posedge pclk);
  endtask
  task automatic wr(input logic [5:0] i, input logic [15:0] d, input logic [3:0] s);
    xf(1'b1, i, d, s);
  endtask
  task automatic rc(input logic [5:0] i, input logic [15:0] e);
    xf(1'b0, i, 16'h0000, 4'h0);
    chk($sformatf("register %h", i), {16'h0000, e}, rd_q);
  endtask
  // Event pulses last exactly one cycle
  task automatic pulse(input logic [5:0] m);
    ev <= m;
    @(posedge pclk);
    ev <= 6'h00;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // ==========================================================
  // Watchdog: whole sequence needs well under 2000 cycles
  initial begin
    tick(20000);
    fails++;
    conclude();
  end
  // ==========================================================
  // Main sequence
  initial begin
    tick(10);
    presetn <= 1'b1;
    @(posedge pclk);
    rc(`SSF_IDX_IRQ_EN, 16'h0000);
    rc(`SSF_IDX_IRQ_FLAGS, 16'h0082);
    rc(`SSF_IDX_PIN_CTL, 16'h000C);
    rc(`SSF_IDX_SYS_CTL, 16'h0000);
    rc(`SSF_IDX_BOOT_CFG, 16'h0003);
    rc(`SSF_IDX_RST_IV, 16'h0002);
    wr(`SSF_IDX_IRQ_EN, 16'hFFFF, 4'h3);
    rc(`SSF_IDX_IRQ_EN, 16'h00DB);
    tick(2);
    chk("osc irq", 1, osc_fault_irq);
    chk("out irq", 1, mailbox_out_irq);
    wr(`SSF_IDX_IRQ_FLAGS, 16'h0000, 4'h1);
    pulse(6'h03);
    rc(`SSF_IDX_IRQ_FLAGS, 16'h000A);
    chk("vacant irq", 1, vacant_access_irq);
    rc(`SSF_IDX_SYS_NMI_IV, `SSF_IV_VACANT);
    rc(`SSF_IDX_USER_NMI_IV, `SSF_IV_OSC);
    // Writing the user vector drops the pin and oscillator flags only
    wr(`SSF_IDX_USER_NMI_IV, 16'h0000, 4'h3);
    rc(`SSF_IDX_IRQ_FLAGS, 16'h0008);
    wr(`SSF_IDX_IRQ_FLAGS, 16'h0000, 4'h1);
    // Upper lane only must leave the pin controls alone
    wr(`SSF_IDX_PIN_CTL, 16'hFFFF, 4'h2);
    rc(`SSF_IDX_PIN_CTL, 16'h000C);
    wr(`SSF_IDX_PIN_CTL, 16'h0002, 4'h1);
    wr(`SSF_IDX_PIN_CTL, 16'h0003, 4'h1);
    rc(`SSF_IDX_PIN_CTL, 16'h0003);
    chk("pull enable", 0, reset_pin_pull_enable);
    chk("pull dir", 0, reset_pin_pull_direction);
    chk("edge", 1, nmi_edge_select);
    chk("nmi function", 1, reset_pin_function_select);
    nmi_pin <= 1'b0;
    tick(6);
    rc(`SSF_IDX_IRQ_FLAGS, 16'h0010);
    chk("nmi irq", 1, nmi_pin_irq);
    wr(`SSF_IDX_IRQ_FLAGS, 16'h0000, 4'h1);
    nmi_pin <= 1'b1;
    tick(6);
    rc(`SSF_IDX_IRQ_FLAGS, 16'h0000);
    // Sticky system bits survive a clearing write
    wr(`SSF_IDX_SYS_CTL, 16'hFFFF, 4'h3);
    rc(`SSF_IDX_SYS_CTL, 16'h0035);
    wr(`SSF_IDX_SYS_CTL, 16'h0000, 4'h3);
    rc(`SSF_IDX_SYS_CTL, 16'h0024);
    chk("debug pins", 1, dedicated_debug_pins);
    chk("ram vectors", 0, ram_vector_select);
    chk("power protect", 1, power_regs_protect);
    pulse(6'h20);
    rc(`SSF_IDX_SYS_CTL, 16'h0034);
    // Mailbox, one-word mode
    dbg.put(0, 3, 16'hA5C3);
    rc(`SSF_IDX_IRQ_FLAGS, 16'h0040);
    chk("in irq", 1, mailbox_in_irq);
    rc(`SSF_IDX_MB_IN0, 16'hA5C3);
    rc(`SSF_IDX_IRQ_FLAGS, 16'h0000);
    dbg.take(0, 0);
    rc(`SSF_IDX_IRQ_FLAGS, 16'h0080);
    wr(`SSF_IDX_MB_OUT0, 16'h1234, 4'h3);
    chk("out word0", 16'h1234, mailbox_output_word0);
    rc(`SSF_IDX_IRQ_FLAGS, 16'h0000);
    dbg.put(0, 0, 16'h0F0F);
    rc(`SSF_IDX_USER_NMI_IV, `SSF_IV_MB_IN);
    rc(`SSF_IDX_IRQ_FLAGS, 16'h0000);
    // Mailbox, two-word mode, words in reverse order except the CPU reads of the input words
    wr(`SSF_IDX_MB_CTL, 16'hFFFF, 4'h3);
    rc(`SSF_IDX_MB_CTL, 16'h0010);
    dbg.put(1, 0, 16'hBEEF);
    rc(`SSF_IDX_IRQ_FLAGS, 16'h0000);
    dbg.put(0, 2, 16'hCAFE);
    rc(`SSF_IDX_IRQ_FLAGS, 16'h0040);
    rc(`SSF_IDX_MB_IN0, 16'hCAFE);
    rc(`SSF_IDX_IRQ_FLAGS, 16'h0040);
    rc(`SSF_IDX_MB_IN1, 16'hBEEF);
    rc(`SSF_IDX_IRQ_FLAGS, 16'h0000);
    dbg.take(1, 2);
    rc(`SSF_IDX_IRQ_FLAGS, 16'h0000);
    dbg.take(0, 0);
    rc(`SSF_IDX_IRQ_FLAGS, 16'h0080);
    wr(`SSF_IDX_MB_OUT1, 16'h5678, 4'h3);
    rc(`SSF_IDX_IRQ_FLAGS, 16'h0080);
    wr(`SSF_IDX_MB_OUT0, 16'h9ABC, 4'h3);
    rc(`SSF_IDX_IRQ_FLAGS, 16'h0000);
    chk("out word1", 16'h5678, mailbox_output_word1);
    // Watchdog, interval mode
    pulse(6'h04);
    rc(`SSF_IDX_IRQ_FLAGS, 16'h0001);
    chk("interval irq", 1, watchdog_interval_irq);
    pulse(6'h10);
    rc(`SSF_IDX_IRQ_FLAGS, 16'h0000);
    pulse(6'h04);
    wr(`SSF_IDX_IRQ_FLAGS, 16'h0000, 4'h1);
    rc(`SSF_IDX_IRQ_FLAGS, 16'h0000);
    // Watchdog mode acts with its enable off
    wr(`SSF_IDX_IRQ_EN, 16'h0000, 4'h3);
    wdt_watchdog_mode <= 1'b1;
    wr(`SSF_IDX_IRQ_FLAGS, 16'h0001, 4'h1);
    pulse(6'h08);
    tick(1);
    chk("reset request", 1, watchdog_reset_req);
    rc(`SSF_IDX_IRQ_FLAGS, 16'h0000);
    rc(`SSF_IDX_RST_IV, `SSF_CAUSE_WDT);
    // Unmapped index is refused
    xf(1'b0, 6'h3F, 16'h0000, 4'h0);
    chk("slave error", 1, er_q);
    chk("unmapped data", 0, rd_q);
    conclude();
  end
endmodule // system_special_function_regs_bench
`default_nettype wire
